/* File: core/fp_unit.v */
// single-precision multiply or add with flush-to-zero, nan-as-infinity and two rounding modes
`timescale 1ns/1ps
module fp_unit #(
  parameter IS_ADD = 0
) (
  input wire [31:0] a,
  input wire [31:0] b,
  input wire rtz,
  output reg [31:0] y
);
  wire [7:0] ea = a[30:23];
  wire [7:0] eb = b[30:23];

  // m holds 24 mantissa bits, guard, round and sticky
  function [31:0] pack;
    input s;
    input signed [10:0] e;
    input [26:0] m;
    input rz;
    reg [24:0] r;
    reg up;
    reg signed [10:0] ee;
    begin
      up = ~rz & m[2] & (m[1] | m[0] | m[3]);
      r = {1'b0, m[26:3]} + {24'h0, up};
      ee = e;
      if (r[24]) begin
        r = r >> 1;
        ee = e + 11'sh001;
      end
      if (ee <= 0)
        pack = {s, 31'h0};
      else if (ee >= 255)
        pack = {s, 8'hff, 23'h0};
      else
        pack = {s, ee[7:0], r[22:0]};
    end
  endfunction

  reg [47:0] p;
  reg [26:0] ma;
  reg [26:0] mb;
  reg [26:0] t;
  reg [27:0] sum;
  reg signed [10:0] e;
  reg [7:0] d;
  reg sa;
  reg sb;
  integer i;

  // exponent 0 means zero or denormal, both taken as signed zero; exponent ff covers nan too
  always @* begin
    p = 48'h0;
    ma = 27'h0;
    mb = 27'h0;
    t = 27'h0;
    sum = 28'h0;
    e = 11'sh000;
    d = 8'h0;
    sa = a[31];
    sb = b[31];
    y = 32'h0;
    if (IS_ADD == 0) begin
      p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
      e = $signed({3'h0, ea}) + $signed({3'h0, eb}) - 11'sh07f;
      if (ea == 8'hff || eb == 8'hff)
        y = {sa ^ sb, 8'hff, 23'h0};
      else if (ea == 8'h00 || eb == 8'h00)
        y = {sa ^ sb, 31'h0};
      else if (p[47])
        y = pack(sa ^ sb, e + 11'sh001, {p[47:22], |p[21:0]}, rtz);
      else
        y = pack(sa ^ sb, e, {p[46:21], |p[20:0]}, rtz);
    end else if (ea == 8'hff) begin
      y = {sa, 8'hff, 23'h0};
    end else if (eb == 8'hff) begin
      y = {sb, 8'hff, 23'h0};
    end else begin
      ma = (ea == 8'h00) ? 27'h0 : {1'b1, a[22:0], 3'h0};
      mb = (eb == 8'h00) ? 27'h0 : {1'b1, b[22:0], 3'h0};
      if ({ea, ma} < {eb, mb}) begin
        t = ma;
        ma = mb;
        mb = t;
        sa = b[31];
        sb = a[31];
        e = $signed({3'h0, eb});
        d = eb - ea;
      end else begin
        e = $signed({3'h0, ea});
        d = ea - eb;
      end
      for (i = 0; i < 27; i = i + 1)
        if (i < d)
          mb = {1'b0, mb[26:2], mb[1] | mb[0]};
      sum = (sa == sb) ? {1'b0, ma} + {1'b0, mb} : {1'b0, ma} - {1'b0, mb};
      if (sum[27]) begin
        t = {sum[27:2], sum[1] | sum[0]};
        e = e + 11'sh001;
      end else begin
        t = sum[26:0];
        for (i = 0; i < 27; i = i + 1)
          if (!t[26] && t != 27'h0) begin
            t = t << 1;
            e = e - 11'sh001;
          end
      end
      if (t == 27'h0)
        y = 32'h0;
      else
        y = pack(sa, e, t, rtz);
    end
  end
endmodule

/* File: core/iir_biquad_channel_sequencer.v */
// wishbone-mapped cascaded biquad channel sequencer over a shared pool of stages
// Behaviour
// - a write to a channel input starts a run through all its stages in order
// - output-ready flag rises once the output is available, before completion; output readable
// - only one channel runs at a time, channels served one after another
// - an input write during any run waits on the bus until the run ends
// - an output read before the result is ready stalls until ready
// - an output read after ready or complete answers with no stall, only the one base wait cycle
// - each stage takes 2 cycles forward plus 5 cycles of state write-back
// - one pool of 32 stages shared among all channels
// - interrupts available on output-ready and on processing-complete
// - samples, coefficients and state are ieee 754 single precision
// - rounding to nearest-even or toward zero, chosen by software
// - denormals act as signed zero, nan acts as infinity
// - with ecc on, single-bit errors corrected and double-bit errors detected; two flips in one state word keep its parity and are taken as corrected
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "iir_map.vh"
module iir_biquad_channel_sequencer (
  input wire clk_sys,
  input wire rst,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq
);
  localparam ST_IDLE = 3'b001;
  localparam ST_FWD = 3'b010;
  localparam ST_WB = 3'b100;

  reg [2:0] fsm_r;
  reg [1:0] cur_ch_r;
  reg [5:0] stg_r;
  reg [2:0] ph_r;
  reg [31:0] t0_r;
  reg [31:0] t1_r;
  reg [31:0] t2_r;
  reg [31:0] t3_r;
  reg [1:0] opctl_r;
  reg [1:0] eccsts_r;
  reg [7:0] sts_r;
  reg [7:0] ie_r;
  reg [10:0] chcfg_r [0:3];
  reg [31:0] out_r [0:3];
  reg [31:0] coef_r [0:159];
  reg [31:0] sv_r [0:63];
  reg [31:0] svc_r [0:63];
  reg sv_p_r [0:63];
  reg [31:0] xin_r [0:32];
  reg [31:0] rdata;
  integer i;
  integer j;

  function [31:0] merge;
    input [31:0] o;
    input [31:0] n;
    input [3:0] s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        merge[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
    end
  endfunction

  // state words are kept with a copy and a parity bit; parity picks the good one of two
  function [33:0] ecc_read;
    input en;
    input [31:0] w;
    input [31:0] c;
    input p;
    begin
      if (!en || w == c)
        ecc_read = {2'b00, w};
      else if (^w == p)
        ecc_read = {2'b01, w};
      else if (^c == p)
        ecc_read = {2'b01, c};
      else
        ecc_read = {2'b10, w};
    end
  endfunction

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire is_op = wb_adr_i == `OPCTL_ADDR;
  wire is_ecc = wb_adr_i == `ECCSTS_ADDR;
  wire is_cfg = wb_adr_i[11:4] == `CFG_PAGE;
  wire is_ch = wb_adr_i[11:6] == `CH_PAGE;
  wire is_stg = wb_adr_i[11:10] == `STG_PAGE;
  wire [1:0] bch = is_ch ? wb_adr_i[5:4] : wb_adr_i[3:2];
  wire [1:0] breg = wb_adr_i[3:2];
  wire [4:0] bstg = wb_adr_i[9:5];
  wire [2:0] bwrd = wb_adr_i[4:2];
  wire [7:0] sw_cidx = {1'b0, bstg, 2'b00} + {3'h0, bstg} + {5'h00, bwrd};
  wire [5:0] sw_sidx = {bstg, ~bwrd[0]};
  wire [33:0] sw_sv = ecc_read(opctl_r[`OPCTL_ECC], sv_r[sw_sidx], svc_r[sw_sidx], sv_p_r[sw_sidx]);
  wire [31:0] wmerged = merge(rdata, wb_dat_i, wb_sel_i);
  wire busy = ~fsm_r[0];

  wire stall_inp = is_ch & wb_we_i & (breg == `REG_INP) & busy;
  // ready shows once the forward pass is over, so a read after the flag never waits
  wire stall_out = is_ch & ~wb_we_i & (breg == `REG_OUT) & (fsm_r == ST_FWD) & (cur_ch_r == bch);
  // coefficient and state updates mid-run would corrupt the active cascade
  wire stall_cfg = (is_stg | is_cfg) & wb_we_i & busy;
  wire stall = stall_inp | stall_out | stall_cfg;
  wire wr_go = req & wb_we_i & wb_ack_o;
  wire rd_go = req & ~wb_we_i & wb_ack_o;
  wire start = wr_go & is_ch & (breg == `REG_INP);

  // engine addressing into the pool
  wire [10:0] cfg_cur = chcfg_r[cur_ch_r];
  wire [5:0] cnt_raw = cfg_cur[10:`CFG_CNT_LSB];
  wire [5:0] ncnt = (cnt_raw > `NUM_STAGES) ? `NUM_STAGES : cnt_raw;
  wire start_zero = chcfg_r[bch][10:`CFG_CNT_LSB] == 6'h00;
  wire [4:0] g = cfg_cur[4:0] + stg_r[4:0];
  wire [7:0] cbase = {1'b0, g, 2'b00} + {3'h0, g};
  wire [31:0] cb0 = coef_r[cbase];
  wire [31:0] cb1 = coef_r[cbase + 8'h01];
  wire [31:0] cb2 = coef_r[cbase + 8'h02];
  wire [31:0] ca1 = coef_r[cbase + 8'h03];
  wire [31:0] ca2 = coef_r[cbase + 8'h04];
  wire [33:0] s1 = ecc_read(opctl_r[`OPCTL_ECC], sv_r[{g, 1'b0}], svc_r[{g, 1'b0}], sv_p_r[{g, 1'b0}]);
  wire [33:0] s2 = ecc_read(opctl_r[`OPCTL_ECC], sv_r[{g, 1'b1}], svc_r[{g, 1'b1}], sv_p_r[{g, 1'b1}]);
  wire [31:0] xv = xin_r[stg_r];
  wire [31:0] yv = xin_r[stg_r + 6'h01];
  wire last = (stg_r + 6'h01) == ncnt;
  wire in_fwd = fsm_r == ST_FWD;
  wire in_wb = fsm_r == ST_WB;
  wire fwd_end = in_fwd & (ph_r == `FWD_CYCLES - 3'h1);
  wire wb_end = in_wb & (ph_r == `WB_CYCLES - 3'h1);

  // transposed direct form: y = b0 x + s1, s1' = b1 x - a1 y + s2, s2' = b2 x - a2 y
  wire wb_y = in_wb & (ph_r == 3'h1);
  wire [31:0] u0a = in_fwd ? cb0 : (wb_y ? ca1 : cb1);
  wire [31:0] u0b = wb_y ? yv : xv;
  wire [31:0] u1a = wb_y ? ca2 : cb2;
  wire [31:0] u1b = wb_y ? yv : xv;
  wire [31:0] u2b = in_fwd ? s1[31:0] : ((ph_r == 3'h2) ? t2_r ^ `FP_SIGN : s2[31:0]);
  wire [31:0] u0y;
  wire [31:0] u1y;
  wire [31:0] u2y;
  wire [31:0] u3y;

  fp_unit #(.IS_ADD(0)) u_mul0 (.a(u0a), .b(u0b), .rtz(opctl_r[`OPCTL_RTZ]), .y(u0y));
  fp_unit #(.IS_ADD(0)) u_mul1 (.a(u1a), .b(u1b), .rtz(opctl_r[`OPCTL_RTZ]), .y(u1y));
  fp_unit #(.IS_ADD(1)) u_add0 (.a(t0_r), .b(u2b), .rtz(opctl_r[`OPCTL_RTZ]), .y(u2y));
  fp_unit #(.IS_ADD(1)) u_add1 (.a(t1_r), .b(t3_r ^ `FP_SIGN), .rtz(opctl_r[`OPCTL_RTZ]), .y(u3y));

  // flag events: set wins over a read-clear in the same cycle
  wire ordy_ev = (fwd_end & last) | (start & start_zero);
  wire cprc_ev = (wb_end & last) | (start & start_zero);
  wire [1:0] ev_ch = start ? bch : cur_ch_r;
  wire [7:0] sts_set = {6'h00, cprc_ev, ordy_ev} << {ev_ch, 1'b0};
  wire [7:0] sts_clr = (rd_go & is_ch & breg == `REG_STS) ? ({6'h00, wb_dat_o[1:0]} << {bch, 1'b0}) : 8'h00;
  wire s1_chk = in_fwd & (ph_r == 3'h1);
  wire s2_chk = in_wb & (ph_r == 3'h3);
  wire [1:0] ecc_set = (s1_chk ? s1[33:32] : 2'b00) | (s2_chk ? s2[33:32] : 2'b00);
  wire [1:0] ecc_clr = (rd_go & is_ecc) ? wb_dat_o[1:0] : 2'b00;

  assign irq = |(sts_r & ie_r);

  always @* begin
    rdata = 32'h0;
    if (is_op)
      rdata = {30'h0, opctl_r};
    else if (is_ecc)
      rdata = {30'h0, eccsts_r};
    else if (is_cfg)
      rdata = {21'h0, chcfg_r[bch]};
    else if (is_ch) begin
      case (breg)
        `REG_OUT: rdata = out_r[bch];
        `REG_STS: rdata = {30'h0, sts_r[{bch, 1'b0} +: 2]};
        `REG_INT: rdata = {30'h0, ie_r[{bch, 1'b0} +: 2]};
        default: rdata = 32'h0;
      endcase
    end else if (is_stg) begin
      if (bwrd < `WORD_S1)
        rdata = coef_r[sw_cidx];
      else if (bwrd < `WORD_END)
        rdata = sw_sv[31:0];
    end
  end

  // bus slave: one wait cycle at least, longer only while a stall holds
  always @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o & ~stall;
      if (req & ~wb_ack_o & ~stall)
        wb_dat_o <= rdata;
    end
  end

  // control registers and flags
  always @(posedge clk_sys) begin
    if (rst) begin
      opctl_r <= `OPCTL_RST;
      eccsts_r <= 2'b00;
      sts_r <= 8'h00;
      ie_r <= 8'h00;
      for (i = 0; i < 4; i = i + 1)
        chcfg_r[i] <= 11'h000;
    end else begin
      sts_r <= (sts_r & ~sts_clr) | sts_set;
      eccsts_r <= (eccsts_r & ~ecc_clr) | ecc_set;
      if (wr_go & is_op)
        opctl_r <= wmerged[1:0];
      if (wr_go & is_cfg)
        chcfg_r[bch] <= wmerged[10:0];
      if (wr_go & is_ch & breg == `REG_INT)
        ie_r[{bch, 1'b0} +: 2] <= wmerged[1:0];
    end
  end

  // sequencer: forward pass over all stages, then state write-back pass
  always @(posedge clk_sys) begin
    if (rst) begin
      fsm_r <= ST_IDLE;
      cur_ch_r <= 2'h0;
      stg_r <= 6'h00;
      ph_r <= 3'h0;
      t0_r <= 32'h0;
      t1_r <= 32'h0;
      t2_r <= 32'h0;
      t3_r <= 32'h0;
      for (j = 0; j < 4; j = j + 1)
        out_r[j] <= 32'h0;
    end else begin
      case (fsm_r)
        ST_IDLE: begin
          if (start) begin
            cur_ch_r <= bch;
            stg_r <= 6'h00;
            ph_r <= 3'h0;
            if (start_zero)
              out_r[bch] <= wb_dat_i;
            else
              fsm_r <= ST_FWD;
          end
        end
        ST_FWD: begin
          if (!fwd_end) begin
            t0_r <= u0y;
            ph_r <= ph_r + 3'h1;
          end else begin
            ph_r <= 3'h0;
            if (last) begin
              out_r[cur_ch_r] <= u2y;
              stg_r <= 6'h00;
              fsm_r <= ST_WB;
            end else
              stg_r <= stg_r + 6'h01;
          end
        end
        ST_WB: begin
          case (ph_r)
            3'h0: begin
              t0_r <= u0y;
              t1_r <= u1y;
            end
            3'h1: begin
              t2_r <= u0y;
              t3_r <= u1y;
            end
            3'h2: begin
              t0_r <= u2y;
              t1_r <= u3y;
            end
            3'h3: t0_r <= u2y;
            default: t0_r <= t0_r;
          endcase
          if (!wb_end)
            ph_r <= ph_r + 3'h1;
          else begin
            ph_r <= 3'h0;
            if (last)
              fsm_r <= ST_IDLE;
            else
              stg_r <= stg_r + 6'h01;
          end
        end
        default: fsm_r <= ST_IDLE;
      endcase
    end
  end

  // pool storage, kept in flip-flops and left unreset on purpose
  always @(posedge clk_sys) begin
    if (start)
      xin_r[0] <= wb_dat_i;
    if (fwd_end)
      xin_r[stg_r + 6'h01] <= u2y;
    if (wr_go & is_stg & bwrd < `WORD_S1)
      coef_r[sw_cidx] <= wmerged;
    if (wr_go & is_stg & bwrd >= `WORD_S1 & bwrd < `WORD_END) begin
      sv_r[sw_sidx] <= wmerged;
      svc_r[sw_sidx] <= wmerged;
      sv_p_r[sw_sidx] <= ^wmerged;
    end
    if (wb_end) begin
      sv_r[{g, 1'b0}] <= t0_r;
      svc_r[{g, 1'b0}] <= t0_r;
      sv_p_r[{g, 1'b0}] <= ^t0_r;
      sv_r[{g, 1'b1}] <= t1_r;
      svc_r[{g, 1'b1}] <= t1_r;
      sv_p_r[{g, 1'b1}] <= ^t1_r;
    end
  end
endmodule

/* File: core/iir_map.vh */
// register map, field positions, reset values and cycle counts of the biquad sequencer
`ifndef IIR_MAP_VH
`define IIR_MAP_VH
`define NUM_STAGES 6'h20
`define FWD_CYCLES 3'h2
`define WB_CYCLES 3'h5
`define OPCTL_ADDR 12'h000
`define ECCSTS_ADDR 12'h004
`define CFG_PAGE 8'h02
`define CH_PAGE 6'h01
`define STG_PAGE 2'h1
`define REG_INP 2'h0
`define REG_OUT 2'h1
`define REG_STS 2'h2
`define REG_INT 2'h3
`define WORD_S1 3'h5
`define WORD_END 3'h7
`define OPCTL_RTZ 0
`define OPCTL_ECC 1
`define CFG_CNT_LSB 5
`define OPCTL_RST 2'h2
`define FP_SIGN 32'h80000000
`endif

/* File: dv/iir_seq_chk.sv */
// concurrent checks on the sequencer bus and interrupt ports
`timescale 1ns/1ps
module iir_seq_chk (
  input wire clk_sys,
  input wire rst,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire rd_ack = wb_ack_o && !wb_we_i;
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  // reset must not be masked here, it is what is being watched
  reset_quiet_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    rst |=> !wb_ack_o && !irq && wb_dat_o == 32'h0) else $error("not quiet in reset");
  stall_bounded_a: assert property (req |-> ##[1:400] wb_ack_o) else $error("stall too long");
  status_no_wait_a: assert property (req && !wb_we_i && wb_adr_i[11:6] == 6'h1 && wb_adr_i[3:2] == 2'h2
    |=> wb_ack_o) else $error("flag read waited");
  unmapped_zero_a: assert property (rd_ack && wb_adr_i[11:5] == 7'h0 && wb_adr_i[4:2] >= 3'h2
    |-> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
  input_reads_zero_a: assert property (rd_ack && wb_adr_i[11:6] == 6'h1 && wb_adr_i[3:2] == 2'h0
    |-> wb_dat_o == 32'h0) else $error("input read nonzero");
  stage_pad_zero_a: assert property (rd_ack && wb_adr_i[11:10] == 2'h1 && wb_adr_i[4:2] == 3'h7
    |-> wb_dat_o == 32'h0) else $error("pad word nonzero");
  read_data_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
  cover property (req [*8]);
  cover property ($rose(irq));
  cover property (rd_ack && wb_adr_i[11:6] == 6'h1 && wb_adr_i[3:2] == 2'h1);
endmodule
bind iir_biquad_channel_sequencer iir_seq_chk i_chk (.clk_sys(clk_sys), .rst(rst), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

/* File: dv/tb.sv */
// self-checking bench for the biquad channel sequencer
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  wire [11:0] wb_adr_i;
  wire [31:0] wb_dat_i;
  wire [3:0] wb_sel_i;
  wire wb_we_i;
  wire wb_cyc_i;
  wire wb_stb_i;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire irq;
  int num_errors = 0;
  int checked = 0;
  time t0 = 0;
  logic [31:0] q;
  int n;
  logic [31:0] din [4] = '{32'h00000001, 32'h80000001, 32'h7fc00000, 32'hffc00000};
  logic [31:0] dex [4] = '{32'h00000000, 32'h00000000, 32'h7f800000, 32'hff800000};
  always #25 clk_sys = ~clk_sys;
  iir_biquad_channel_sequencer i_dut (.clk_sys(clk_sys), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq(irq));
  wb_host i_host (.clk_sys(clk_sys), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    int k;
    i_host.xfer(1'b1, a, d, r, k);
  endtask
  task automatic rd(input logic [11:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, n);
  endtask
  function automatic int since();
    return int'(($time - t0) / 50);
  endfunction
  task automatic in_range(input int k, input int lo, input int hi);
    check({31'h0, k >= lo && k <= hi}, 32'h1);
  endtask
  // the host waits on the flag line rather than stalling the bus
  task automatic wait_irq();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (irq !== 1'b1 && k < 500);
    check({31'h0, irq}, 32'h1);
  endtask
  task automatic ld(input int s, input logic [31:0] b0);
    for (int k = 0; k < 7; k++) wr(12'h400 + 12'(s * 32 + k * 4), k == 0 ? b0 : 32'h0);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    num_errors++;
    $display("BAD t=%0t got %h exp %h", $time, 32'h0, 32'h1);
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h000);
    check(q, 32'h2);
    rd(12'h004);
    check(q, 32'h0);
    wr(12'h008, 32'h5a5a5a5a);
    rd(12'h008);
    check(q, 32'h0);
    rd(12'h41c);
    check(q, 32'h0);
    rd(12'h040);
    check(q, 32'h0);
    $display("test map done");
    ld(0, 32'h40000000);
    ld(1, 32'h40000000);
    ld(2, 32'h3fc00000);
    rd(12'h400);
    check(q, 32'h40000000);
    rd(12'h414);
    check(q, 32'h0);
    wr(12'h020, 32'h40);
    wr(12'h028, 32'h22);
    rd(12'h020);
    check(q, 32'h40);
    wr(12'h04c, 32'h3);
    wr(12'h040, 32'h3fc00000);
    t0 = $time;
    wait_irq();
    check(since() - 1, 4);
    rd(12'h048);
    check(q, 32'h1);
    wait_irq();
    check(since() - 1, 14);
    rd(12'h048);
    check(q, 32'h2);
    rd(12'h048);
    check(q, 32'h0);
    check({31'h0, irq}, 32'h0);
    rd(12'h044);
    check(q, 32'h40c00000);
    check(n, 2);
    $display("test timing done");
    wr(12'h04c, 32'h0);
    wr(12'h040, 32'h3f800000);
    repeat (20) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    wr(12'h04c, 32'h3);
    @(negedge clk_sys);
    check({31'h0, irq}, 32'h1);
    rd(12'h048);
    check(q, 32'h3);
    @(negedge clk_sys);
    check({31'h0, irq}, 32'h0);
    rd(12'h044);
    check(q, 32'h40800000);
    $display("test mask done");
    wr(12'h040, 32'h3fc00000);
    t0 = $time;
    wr(12'h050, 32'h12345678);
    in_range(since(), 15, 17);
    rd(12'h054);
    check(q, 32'h12345678);
    rd(12'h044);
    check(q, 32'h40c00000);
    rd(12'h048);
    wr(12'h040, 32'h3f800000);
    t0 = $time;
    rd(12'h044);
    in_range(since(), 5, 7);
    check(q, 32'h40800000);
    repeat (20) @(posedge clk_sys);
    rd(12'h048);
    $display("test stall done");
    for (int i = 0; i < 4; i++) begin
      ld(0, 32'h40000000);
      ld(1, 32'h40000000);
      wr(12'h040, din[i]);
      rd(12'h044);
      check(q, dex[i]);
      repeat (20) @(posedge clk_sys);
    end
    // first pass runs nearest with ecc off, second toward zero with ecc on
    for (int m = 0; m < 2; m++) begin
      wr(12'h000, 32'(3 * m));
      wr(12'h060, 32'h3f800001);
      rd(12'h064);
      check(q, m == 1 ? 32'h3fc00001 : 32'h3fc00002);
    end
    $display("test arith done");
    finish_test();
  end
endmodule

/* File: dv/wb_host.sv */
// processor-side wishbone master that feeds and drains the channels
`timescale 1ns/1ps
module wb_host (
  input wire clk_sys,
  input wire wb_ack_o,
  input wire [31:0] wb_dat_o,
  output logic [11:0] wb_adr_i,
  output logic [31:0] wb_dat_i,
  output logic [3:0] wb_sel_i,
  output logic wb_we_i,
  output logic wb_cyc_i,
  output logic wb_stb_i
);
  initial begin
    wb_adr_i = 12'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
  end
  // one word per transfer from the core, never a burst engine
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output int n);
    @(posedge clk_sys);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    // released lines show junk so a late sample cannot pass by luck
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
  endtask
endmodule
